// ### src/drive_position_orient_fastdisable.v
`timescale 1ns/100ps
`default_nettype none
`include "drive_defs.vh"
module drive_position_orient_fastdisable (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        sto_i,
  input  wire        dio_i,
  input  wire        at_speed_i,
  input  wire [15:0] motor_speed_i,
  input  wire [15:0] ref_enc_speed_i,
  input  wire [15:0] ref_pos_i,
  input  wire [15:0] fb_pos_i,
  output reg  [15:0] speed_ref_o,
  output reg         drive_en_o,
  output reg         orient_done_o,
  output reg         pos_loop_o
);
  localparam [5:0] ST_OFF   = 6'h01;
  localparam [5:0] ST_RUN   = 6'h02;
  localparam [5:0] ST_STOP  = 6'h04;
  localparam [5:0] ST_ORAMP = 6'h08;
  localparam [5:0] ST_CREEP = 6'h10;
  localparam [5:0] ST_HOLD  = 6'h20;

  reg        [15:0] ctrl_q;
  reg signed [15:0] dem_q;
  reg        [7:0]  boost_q;
  reg        [15:0] olim_q;
  reg        [15:0] owin_q;
  reg signed [15:0] jog_q;
  reg        [15:0] opos_q;
  reg        [7:0]  kp_q;
  reg        [7:0]  rstep_q;
  reg        [5:0]  st_q;
  reg        [5:0]  st_d;
  reg signed [15:0] spd_q;
  reg signed [15:0] spd_d;
  reg               odir_q;
  reg               odir_d;
  reg signed [23:0] pe_q;
  reg        [15:0] rprev_q;
  reg        [15:0] fprev_q;
  reg               hw_en_q;
  reg               en_in_q;
  wire              wb_req;
  wire              wb_wr;

  function signed [15:0] sat16;
    input signed [39:0] v;
    begin
      if (v > 40'sd32767)
        sat16 = 16'sh7fff;
      else if (v < -40'sd32768)
        sat16 = 16'sh8000;
      else
        sat16 = v[15:0];
    end
  endfunction

  function signed [15:0] ramp;
    input signed [15:0] cur;
    input signed [15:0] tgt;
    input        [7:0]  step;
    input               en;
    reg signed   [17:0] diff;
    begin
      diff = {{2{tgt[15]}}, tgt} - {{2{cur[15]}}, cur};
      if (!en)
        ramp = tgt;
      else if (diff > $signed({10'h000, step}))
        ramp = cur + $signed({8'h00, step});
      else if (diff < -$signed({10'h000, step}))
        ramp = cur - $signed({8'h00, step});
      else
        ramp = tgt;
    end
  endfunction

  function [16:0] mag;
    input signed [15:0] v;
    begin
      mag = v[15] ? (17'd0 - {v[15], v}) : {1'b0, v};
    end
  endfunction

  wire [1:0] ccs      = ctrl_q[`B_CCS_H:`B_CCS_L];
  wire [1:0] fbs      = ctrl_q[`B_FBS_H:`B_FBS_L];
  wire [2:0] pmode    = ctrl_q[`B_PM_H:`B_PM_L];
  wire [1:0] stopm    = ctrl_q[`B_STOP_H:`B_STOP_L];
  wire       run      = ctrl_q[`B_RUN];
  wire       hold     = ctrl_q[`B_HOLD];
  wire       ramp_en  = ctrl_q[`B_RAMPEN];
  wire       cl       = ctrl_q[`B_CL];

  // The fast path is pure gating on a sampled pin, so it acts in one cycle, far inside the bound.
  wire fd_ok = ctrl_q[`B_FDROUTE] ? (dio_i ^ ctrl_q[`B_FDINV]) : 1'b1;
  wire hw_ok = fd_ok & sto_i;

  // Mode decode.
  wire rigid    = (pmode == 3'd1) | (pmode == 3'd2);
  wire nonrigid = (pmode == 3'd3) | (pmode == 3'd4);
  wire ff_on    = (pmode == 3'd1) | (pmode == 3'd3);
  wire orient   = (pmode == 3'd5) | (pmode == 3'd6);
  wire loop_on  = rigid | (nonrigid & at_speed_i);

  wire signed [15:0] dref = ref_pos_i - rprev_q;
  wire signed [15:0] dfb  = fb_pos_i - fprev_q;
  wire signed [15:0] jstep = ctrl_q[`B_JOG] ? jog_q : 16'sh0000;
  // Non-rigid clears the error while off speed, so slip is forgotten.
  wire signed [23:0] pe_d = loop_on
    ? (pe_q + {{8{dref[15]}}, dref} - {{8{dfb[15]}}, dfb} + {{8{jstep[15]}}, jstep}) : 24'sh000000;
  // Proportional term only; without feed-forward a lag grows with speed.
  wire signed [15:0] corr = sat16(($signed({{16{pe_q[23]}}, pe_q}) * $signed({32'h0, kp_q})) >>> `KP_SHIFT);
  wire signed [15:0] ff   = ff_on ? $signed(ref_enc_speed_i) : 16'sh0000;
  wire signed [15:0] tgt  = sat16({{24{dem_q[15]}}, dem_q} + {{24{ff[15]}}, ff}
                                  + (loop_on ? {{24{corr[15]}}, corr} : 40'sh0));

  wire signed [15:0] oe    = $signed(opos_q - fb_pos_i);
  wire signed [15:0] ohold = sat16(($signed({{24{oe[15]}}, oe}) * $signed({32'h0, kp_q})) >>> `KP_SHIFT);
  wire               onear = mag(oe) < `NEAR_TARGET;
  wire               odone = mag(oe) <= {1'b0, owin_q};
  wire signed [15:0] olim  = odir_q ? -$signed(olim_q) : $signed(olim_q);

  // Speed caught at enable; boost scales detection without an encoder.
  wire               boosted = !cl | (fbs == 2'd1) | (fbs == 2'd3);
  wire signed [31:0] bprod   = $signed({{16{motor_speed_i[15]}}, motor_speed_i}) * $signed({24'h0, boost_q});
  // The product must stay signed, or the shift would fill a reverse speed with zeros.
  wire signed [15:0] bspd    = sat16(($signed({{8{bprod[31]}}, bprod}) * `BOOST_MUL) >>> `BOOST_SHIFT);
  wire signed [15:0] det     = boosted ? bspd : $signed(motor_speed_i);
  reg  signed [15:0] catch_spd;

  always @* begin
    catch_spd = 16'sh0000;
    if (cl) begin
      if (ccs != 2'd0)
        catch_spd = det;
    end else begin
      case (ccs)
        2'd1: catch_spd = det;
        2'd2: catch_spd = det[15] ? 16'sh0000 : det;
        2'd3: catch_spd = det[15] ? det : 16'sh0000;
        default: catch_spd = 16'sh0000;
      endcase
    end
  end

  always @* begin
    st_d   = st_q;
    spd_d  = spd_q;
    odir_d = odir_q;
    case (st_q)
      ST_OFF: begin
        spd_d = 16'sh0000;
        if (hw_ok & run) begin
          spd_d = catch_spd;
          if ((pmode == 3'd6) & hold) begin
            st_d   = ST_ORAMP;
            odir_d = catch_spd[15];
          end else begin
            st_d = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        spd_d = ramp(spd_q, tgt, rstep_q, ramp_en);
        if (!run) begin
          if (orient) begin
            st_d   = ST_ORAMP;
            odir_d = spd_q[15];
          end else if (stopm == 2'd0) begin
            st_d = ST_OFF;
          end else begin
            st_d = ST_STOP;
          end
        end
      end
      ST_STOP: begin
        spd_d = ramp(spd_q, 16'sh0000, rstep_q, ramp_en);
        if (run)
          st_d = ST_RUN;
        else if (spd_q == 16'sh0000)
          st_d = ST_OFF;
      end
      ST_ORAMP: begin
        spd_d = ramp(spd_q, olim, rstep_q, ramp_en);
        if (spd_q == olim)
          st_d = ST_CREEP;
      end
      ST_CREEP: begin
        spd_d = olim;
        if (onear)
          st_d = ST_HOLD;
      end
      ST_HOLD: begin
        spd_d = ohold;
        // Leave only once the done flag has stood for a cycle, so it is never lost.
        if (odone & orient_done_o & run)
          st_d = ST_RUN;
        else if (odone & orient_done_o & !hold)
          st_d = ST_OFF;
      end
      default: begin
        st_d  = ST_OFF;
        spd_d = 16'sh0000;
      end
    endcase
    // Losing either enable drops the drive from any state at once.
    if (!hw_ok) begin
      st_d  = ST_OFF;
      spd_d = 16'sh0000;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      st_q          <= ST_OFF;
      spd_q         <= 16'sh0000;
      odir_q        <= 1'b0;
      pe_q          <= 24'sh000000;
      rprev_q       <= 16'h0000;
      fprev_q       <= 16'h0000;
      hw_en_q       <= 1'b0;
      en_in_q       <= 1'b0;
      speed_ref_o   <= 16'h0000;
      drive_en_o    <= 1'b0;
      orient_done_o <= 1'b0;
      pos_loop_o    <= 1'b0;
    end else begin
      st_q          <= st_d;
      spd_q         <= spd_d;
      odir_q        <= odir_d;
      pe_q          <= pe_d;
      rprev_q       <= ref_pos_i;
      fprev_q       <= fb_pos_i;
      en_in_q       <= sto_i;
      if (!ctrl_q[`B_FDROUTE])
        hw_en_q <= sto_i;
      speed_ref_o   <= spd_d;
      drive_en_o    <= (st_d != ST_OFF);
      orient_done_o <= (st_d == ST_HOLD) & odone;
      pos_loop_o    <= (st_d == ST_HOLD) | ((st_d == ST_RUN) & loop_on);
    end
  end

  // Single-cycle answer: ack rises the edge after the request and drops the next.
  assign wb_req = wb_cyc_i & wb_stb_i & !wb_ack_o;
  // Writes land at the edge where the master samples ack, as a classic cycle defines it.
  assign wb_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q   <= `CTRL_RST;
      dem_q    <= 16'sh0000;
      boost_q  <= `BOOST_RST;
      olim_q   <= 16'h0000;
      owin_q   <= 16'h0000;
      jog_q    <= 16'sh0000;
      opos_q   <= 16'h0000;
      kp_q     <= `KP_RST;
      rstep_q  <= `RSTEP_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_wr) begin
        case (wb_adr_i)
          `A_CTRL: begin
            if (wb_sel_i[0])
              ctrl_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              ctrl_q[15:8] <= wb_dat_i[15:8];
          end
          `A_DEMAND: begin
            if (wb_sel_i[0])
              dem_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              dem_q[15:8] <= wb_dat_i[15:8];
          end
          `A_BOOST: begin
            // Values above ten point zero are clipped rather than refused.
            if (wb_sel_i[0])
              boost_q <= (wb_dat_i[7:0] > 8'h64) ? 8'h64 : wb_dat_i[7:0];
          end
          `A_ORIENT: begin
            if (wb_sel_i[0])
              olim_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              olim_q[15:8] <= wb_dat_i[15:8];
            if (wb_sel_i[2])
              owin_q[7:0] <= wb_dat_i[23:16];
            if (wb_sel_i[3])
              owin_q[15:8] <= wb_dat_i[31:24];
          end
          `A_JOG: begin
            if (wb_sel_i[0])
              jog_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              jog_q[15:8] <= wb_dat_i[15:8];
            if (wb_sel_i[2])
              opos_q[7:0] <= wb_dat_i[23:16];
            if (wb_sel_i[3])
              opos_q[15:8] <= wb_dat_i[31:24];
          end
          `A_GAIN: begin
            if (wb_sel_i[0])
              kp_q <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              rstep_q <= wb_dat_i[15:8];
          end
          default: begin
            ctrl_q <= ctrl_q;
          end
        endcase
      end
      if (wb_req & !wb_we_i) begin
        case (wb_adr_i)
          `A_CTRL:   wb_dat_o <= {16'h0000, ctrl_q};
          `A_DEMAND: wb_dat_o <= {16'h0000, dem_q};
          `A_BOOST:  wb_dat_o <= {24'h000000, boost_q};
          `A_ORIENT: wb_dat_o <= {owin_q, olim_q};
          `A_JOG:    wb_dat_o <= {opos_q, jog_q};
          `A_GAIN:   wb_dat_o <= {16'h0000, rstep_q, kp_q};
          `A_STATUS: wb_dat_o <= {18'h00000, st_q, pos_loop_o, fd_ok, hw_ok,
                                  en_in_q, hw_en_q, drive_en_o, orient_done_o, 1'b0};
          `A_SPEED:  wb_dat_o <= {16'h0000, spd_q};
          `A_POSERR: wb_dat_o <= {{8{pe_q[23]}}, pe_q};
          default:   wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### src/drive_defs.vh
// How it works
// - No catch: reference starts at zero, ramps.
// - Catch: reference starts at measured speed.
// - Boost scales detected speed, open-loop/sensorless.
// - Decode position modes zero to six.
// - Rigid mode always accumulates position error.
// - Non-rigid loop closes only at speed.
// - Feed-forward from reference encoder speed.
// - Position loop is proportional only.
// - Modes two and four drop feed-forward.
// - Relative jog shifts feedback at jog speed.
// - Mode five orients on stop, holds or disables.
// - Mode six also orients on enable with hold.
// - Orient first ramps to limit, same direction.
// - Then creep to 1/32 rev, zero demand.
// - Done flag when error inside window.
// - Stop mode ignored while orientation enabled.
// - Hardware enable bit mirrors enable input until routed, then holds.
// - Routed input becomes fast disable instead.
// - Fast disable acts well within 600 us.
// - Enable needs fast input AND safe torque.
// - Open-loop catch: off, all, positive, negative.
`ifndef DRIVE_DEFS_VH
`define DRIVE_DEFS_VH
`define A_CTRL       8'h00
`define A_DEMAND     8'h04
`define A_BOOST      8'h08
`define A_ORIENT     8'h0c
`define A_JOG        8'h10
`define A_GAIN       8'h14
`define A_STATUS     8'h18
`define A_SPEED      8'h1c
`define A_POSERR     8'h20
`define B_RUN        0
`define B_CCS_L      1
`define B_CCS_H      2
`define B_CL         3
`define B_FBS_L      4
`define B_FBS_H      5
`define B_HOLD       6
`define B_FDROUTE    7
`define B_FDINV      8
`define B_PM_L       9
`define B_PM_H       11
`define B_JOG        12
`define B_STOP_L     13
`define B_STOP_H     14
`define B_RAMPEN     15
`define CTRL_RST     16'h8008
`define BOOST_RST    8'h0a
`define KP_RST       8'h10
`define RSTEP_RST    8'h04
`define BOOST_MUL    32'sd205
`define BOOST_SHIFT  11
`define KP_SHIFT     4
`define NEAR_TARGET  17'd2048
`define FAST_DIS_US  600
`define STO_DIS_MS   20
`define CLK_MHZ      20
`endif

// ### dv/drive_checker.sv
`timescale 1ns/100ps
`default_nettype none
module drive_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sto_i,
  input wire logic        drive_en_o,
  input wire logic        orient_done_o,
  input wire logic        pos_loop_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ack; s_req |=> s_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack missing or too long");
  property p_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_cause: assert property (p_cause) else $error("ack without request");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  // Read data must survive writes, since software may read it late.
  property p_hold; !(wb_ack_o && !wb_we_i) |-> $stable(wb_dat_o); endproperty
  a_hold: assert property (p_hold) else $error("read data changed");
  property p_sto; !sto_i |=> !drive_en_o; endproperty
  a_sto: assert property (p_sto) else $error("enable kept without safe torque");
  property p_rise; $rose(drive_en_o) |-> $past(sto_i); endproperty
  a_rise: assert property (p_rise) else $error("enable without safe torque");
  property p_done; $rose(orient_done_o) |-> pos_loop_o && drive_en_o; endproperty
  a_done: assert property (p_done) else $error("done without position loop");
  property p_loop; $rose(pos_loop_o) |-> drive_en_o; endproperty
  a_loop: assert property (p_loop) else $error("loop on while disabled");
endmodule
bind drive_position_orient_fastdisable drive_checker i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_dat_o, .wb_ack_o, .sto_i, .drive_en_o, .orient_done_o, .pos_loop_o);
`default_nettype wire

// ### dv/motor_model.sv
`timescale 1ns/100ps
`default_nettype none
module motor_model #(
  parameter logic [15:0] SPIN = 16'h0100
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        drive_en_i,
  input  wire logic [15:0] speed_ref_i,
  output logic      [15:0] motor_speed_o,
  output logic      [15:0] fb_pos_o
);
  logic [15:0] pos_q;
  // A coasting shaft keeps turning, so a catch always has a speed to find.
  assign motor_speed_o = drive_en_i ? speed_ref_i : SPIN;
  assign fb_pos_o = pos_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_q <= 16'h0000;
    end else begin
      pos_q <= pos_q + motor_speed_o;
    end
  end
endmodule
`default_nettype wire

// ### dv/drive_position_orient_fastdisable_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "drive_defs.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module drive_position_orient_fastdisable_tb_top;
  logic        clk_i, rst_i, cyc, stb, we, sto, dio, ack, den, odone, ploop, at_spd;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, r;
  logic [15:0] mspd, fpos, spd, ref_spd;
  int          n_fail, comparisons;
  drive_position_orient_fastdisable i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sto_i(sto),
    .dio_i(dio), .at_speed_i(at_spd), .motor_speed_i(mspd), .ref_enc_speed_i(ref_spd), .ref_pos_i(16'h0000),
    .fb_pos_i(fpos), .speed_ref_o(spd), .drive_en_o(den), .orient_done_o(odone), .pos_loop_o(ploop));
  motor_model i_motor (.clk_i, .rst_i, .drive_en_i(den), .speed_ref_i(spd), .motor_speed_o(mspd),
    .fb_pos_o(fpos));
  always #25 clk_i = ~clk_i;
  task automatic tally_and_finish;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      n_fail++;
      tally_and_finish();
    end
    @(posedge clk_i);
  endtask
  task automatic wait_on(input logic od, input logic v, input int lim);
    int n;
    n = 0;
    while ((od ? odone : den) !== v) begin
      @(posedge clk_i);
      n++;
      if (n > lim) begin
        n_fail++;
        tally_and_finish();
      end
    end
  endtask
  task automatic t_regs;
    wb(0, `A_CTRL, 0);
    `CHK("ctrl", 32'h00008008, r)
    wb(0, `A_BOOST, 0);
    `CHK("boost", 32'h0000000a, r)
    wb(1, 8'h24, 32'hffffffff);
    wb(0, 8'h24, 0);
    `CHK("unmapped", 32'h00000000, r)
    wb(1, `A_BOOST, 32'h000000c8);
    wb(0, `A_BOOST, 0);
    `CHK("boost clip", 32'h00000064, r)
    wb(1, `A_BOOST, 32'h00000014);
  endtask
  task automatic t_catch;
    logic [15:0] c [5] = '{16'h8009, 16'h800b, 16'h8003, 16'h8005, 16'h8007};
    logic [15:0] e [5] = '{16'h0000, 16'h0100, 16'h0200, 16'h0200, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      wb(1, `A_CTRL, {16'h0000, c[i]});
      wait_on(0, 1, 5);
      `CHK("start speed", e[i], spd)
      wb(1, `A_CTRL, {16'h0000, c[i] & 16'hfffe});
      wait_on(0, 0, 5);
    end
  endtask
  task automatic t_fast;
    wb(0, `A_STATUS, 0);
    `CHK("enable bits", 2'b11, r[4:3])
    dio <= 1'b1;
    wb(1, `A_CTRL, 32'h00008089);
    wait_on(0, 1, 5);
    dio <= 1'b0;
    wait_on(0, 0, 3);
    wb(1, `A_CTRL, 32'h00008189);
    wait_on(0, 1, 5);
    sto <= 1'b0;
    wait_on(0, 0, 3);
    wb(0, `A_STATUS, 0);
    `CHK("frozen enable bit", 2'b01, r[4:3])
    sto <= 1'b1;
    wb(1, `A_CTRL, 32'h00008008);
    wait_on(0, 0, 5);
  endtask
  task automatic t_orient;
    logic signed [15:0] d;
    // A gain of one rings forever against the two cycles of plant delay, so soften it.
    wb(1, `A_GAIN, 32'h00000404);
    wb(1, `A_ORIENT, 32'h00400100);
    wb(1, `A_JOG, 32'h40000000);
    wb(1, `A_DEMAND, 32'h00000080);
    for (int h = 0; h < 2; h++) begin
      wb(1, `A_CTRL, 32'h00008a09 | (h << 6));
      wait_on(0, 1, 5);
      // Let the ramp reach demand so the stop starts from a known direction.
      repeat (60) @(posedge clk_i);
      wb(1, `A_CTRL, 32'h00008a08 | (h << 6));
      wait_on(1, 1, 3000);
      d = fpos - 16'h4000;
      `CHK("loop engaged", 1'b1, ploop)
      `CHK("in window", 1'b1, d <= 64 && d >= -64)
      repeat (4) @(posedge clk_i);
      `CHK("held enable", h[0], den)
      sto <= 1'b0;
      wait_on(0, 0, 3);
      sto <= 1'b1;
    end
    wb(1, `A_CTRL, 32'h00008c49);
    wait_on(1, 1, 3000);
    `CHK("orient on enable", 1'b1, den)
    wb(1, `A_CTRL, 32'h00008008);
    wait_on(0, 0, 3000);
  endtask
  task automatic t_modes;
    // Gain zero keeps the position term out, so the reference is demand plus feed-forward.
    wb(1, `A_GAIN, 32'h00000400);
    ref_spd <= 16'h0030;
    for (int m = 1; m < 5; m++) begin
      wb(1, `A_CTRL, 32'h00000009 | (m << 9));
      repeat (4) @(posedge clk_i);
      `CHK("mode speed", ((m % 2) ? 16'h00b0 : 16'h0080), spd)
      `CHK("mode loop", (m < 3), ploop)
      at_spd <= 1'b1;
      repeat (2) @(posedge clk_i);
      `CHK("loop at speed", 1'b1, ploop)
      at_spd <= 1'b0;
      wb(1, `A_CTRL, 32'h00000008);
      wait_on(0, 0, 5);
    end
    ref_spd <= 16'h0000;
  endtask
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {cyc, stb, we, dio, at_spd, adr, wdat, ref_spd} = '0;
    sto = 1'b1;
    n_fail = 0;
    comparisons = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_catch();
    t_fast();
    t_orient();
    t_modes();
    tally_and_finish();
  end
endmodule
`default_nettype wire
